// file: rtl/conv_params.svh
// Constants for the serial converter readout block
`ifndef CONV_PARAMS_SVH
`define CONV_PARAMS_SVH

// ------------------------------------------------------------
// Result codes
// ------------------------------------------------------------
`define LOWEST_OUTPUT_CODE 12'h000
`define CENTER_OUTPUT_CODE 12'h800
`define HIGHEST_OUTPUT_CODE 12'hfff
`define RESULT_WIDTH 12

// ------------------------------------------------------------
// Frame edge counts
// ------------------------------------------------------------
`define LEAD_ZERO_BITS 2
`define DATA_EDGES 14
`define POWERUP_CAL_EDGES 16
`define RECAL_START_EDGE 17
`define RECAL_END_EDGE 32
`define EDGE_COUNT_WIDTH 6

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CLK_PERIOD_PS 25000
`define ACQUISITION_INTERVAL_NS 200
`define ACQUISITION_CYCLES ((`ACQUISITION_INTERVAL_NS * 1000 + \
    `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define SELECT_TO_CLOCK_SETUP_NS 15

`endif

// file: rtl/conv_pkg.sv
// Types shared by the serial converter readout block
package conv_pkg;

    typedef logic [11:0] code_t;

    // Frame states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_CONV = 4'b0010,
        ST_CAL = 4'b0100,
        ST_TAIL = 4'b1000
    } frame_e;

endpackage

// file: rtl/pin_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module pin_sync #(
    parameter int WIDTH = 2,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Pins in, synchronised out
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_sync_out
);
    logic [WIDTH-1:0] meta_reg;

    // Refuse a width that leaves nothing to synchronise
    if (WIDTH < 1)
    begin : g_width_check
        $error("pin_sync: WIDTH must be at least 1");
    end

    // First stage is read only by the second stage; reset to the idle
    // pin levels so that no false edge follows reset
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta_reg <= RESET_VALUE;
            pin_sync_out <= RESET_VALUE;
        end
        else
        begin
            meta_reg <= pin_in;
            pin_sync_out <= meta_reg;
        end
    end
endmodule // pin_sync

// file: rtl/offset_corrector.sv
// Saturating offset correction of a raw conversion code
`timescale 1ns/10ps
module offset_corrector #(
    parameter int WIDTH = 12
) (
    // Raw code and signed offset
    input wire logic [WIDTH-1:0] raw_code,
    input wire logic signed [WIDTH-1:0] offset,
    // Corrected code
    output logic [WIDTH-1:0] corrected_code
);
    logic signed [WIDTH+1:0] sum;

    // Saturation needs at least two code bits
    if (WIDTH < 2)
    begin : g_width_check
        $error("offset_corrector: WIDTH too small");
    end

    // Subtract measured offset, clamp to the code range
    always_comb
    begin
        sum = $signed({2'b00, raw_code}) - (WIDTH+2)'(offset);
        if (sum < 0)
        begin
            corrected_code = '0;
        end
        else if (sum > $signed({2'b00, {WIDTH{1'b1}}}))
        begin
            corrected_code = '1;
        end
        else
        begin
            corrected_code = sum[WIDTH-1:0];
        end
    end
endmodule // offset_corrector

// file: rtl/sar_readout.sv
// Serial readout and offset calibration control of a 12-bit converter
//
// How it works
// - Result is a 12-bit straight binary code, 000 low, 800 mid, fff top.
// - A frame runs from select falling to select rising.
// - Output is two zero bits then the twelve result bits.
// - First zero drives at select fall; later bits on clock falls.
// - After fourteen clocks the data line stays low until frame end.
// - Select rising ends the frame and releases the data line.
// - Sample taken at select fall is converted over the first 14 clocks.
// - First frame after power-up calibrates; needs sixteen falling edges.
// - Data line stays low through the power-up calibration frame.
// - A short power-up frame leaves the offset store unchanged.
// - Offset store is internal, unreachable, and cleared at power-up.
// - Later conversions are corrected by the stored offset.
// - Normal frames of 32 or more edges recalibrate from edge 17 to 32.
// - A normal frame shorter than 32 edges leaves the store unchanged.
`timescale 1ns/10ps
`include "conv_params.svh"
module sar_readout #(
    parameter int RES_WIDTH = `RESULT_WIDTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Serial pins
    input wire logic select_b,
    input wire logic serial_clk,
    output logic data_out,
    output logic data_out_en,
    // Analog core: sample strobe, comparator decisions, offset measurement
    input wire conv_pkg::code_t raw_code,
    input wire conv_pkg::code_t offset_measured,
    output logic sample_hold,
    output logic cal_active
);
    import conv_pkg::*;

    // The shift path is built for one result width only
    if (RES_WIDTH != `RESULT_WIDTH)
    begin : g_width_check
        $error("sar_readout: only a 12-bit result is supported");
    end

    // ------------------------------------------------------------
    // Pin synchronisation and edge detection
    // ------------------------------------------------------------
    logic [1:0] pins_sync;
    logic select_b_s;
    logic sclk_s;
    logic select_b_d_reg;
    logic sclk_d_reg;
    logic frame_start;
    logic frame_end;
    logic sclk_fall;

    pin_sync #(
        .WIDTH(2),
        .RESET_VALUE(2'b11)
    ) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .pin_in({select_b, serial_clk}),
        .pin_sync_out(pins_sync)
    );

    assign select_b_s = pins_sync[1];
    assign sclk_s = pins_sync[0];

    // Delayed copies read only synchronised values; reset matches the
    // synchroniser so the first edges after reset are not false
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            select_b_d_reg <= 1'b1;
            sclk_d_reg <= 1'b1;
        end
        else
        begin
            select_b_d_reg <= select_b_s;
            sclk_d_reg <= sclk_s;
        end
    end

    assign frame_start = select_b_d_reg && !select_b_s;
    assign frame_end = !select_b_d_reg && select_b_s;
    assign sclk_fall = !select_b_s && sclk_d_reg && !sclk_s;

    // ------------------------------------------------------------
    // Frame control
    // ------------------------------------------------------------
    frame_e state_reg;
    logic [`EDGE_COUNT_WIDTH-1:0] edge_cnt_reg;
    logic [`EDGE_COUNT_WIDTH-1:0] edge_cnt_next;
    logic powered_cal_done_reg;
    logic cal_frame_reg;
    logic signed [11:0] offset_store_reg;
    code_t corrected;
    logic [13:0] shift_reg;

    // Saturating edge count, never wraps in long frames
    assign edge_cnt_next = (edge_cnt_reg == '1) ? edge_cnt_reg :
        edge_cnt_reg + `EDGE_COUNT_WIDTH'(1);

    // Frame state machine
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg <= ST_IDLE;
        end
        else if (frame_end)
        begin
            state_reg <= ST_IDLE;
        end
        else
        begin
            unique case (state_reg)
                ST_IDLE:
                begin
                    if (frame_start)
                    begin
                        state_reg <= powered_cal_done_reg ? ST_CONV
                            : ST_CAL;
                    end
                end
                ST_CONV:
                begin
                    if (sclk_fall &&
                        edge_cnt_next == `EDGE_COUNT_WIDTH'(`DATA_EDGES))
                    begin
                        state_reg <= ST_TAIL;
                    end
                end
                ST_CAL, ST_TAIL:
                begin
                    state_reg <= state_reg; // Held until select rises
                end
            endcase
        end
    end

    // Falling edges counted within the frame
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            edge_cnt_reg <= '0;
        end
        else if (frame_start)
        begin
            edge_cnt_reg <= '0;
        end
        else if (sclk_fall && state_reg != ST_IDLE)
        begin
            edge_cnt_reg <= edge_cnt_next;
        end
    end

    // Power-up calibration tracking; a short first frame retries next time
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            powered_cal_done_reg <= 1'b0;
        end
        else if (state_reg == ST_CAL && sclk_fall &&
            edge_cnt_next == `EDGE_COUNT_WIDTH'(`POWERUP_CAL_EDGES))
        begin
            powered_cal_done_reg <= 1'b1;
        end
    end

    // Calibration window flag drives the analog core
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cal_frame_reg <= 1'b0;
        end
        else if (frame_end || frame_start)
        begin
            cal_frame_reg <= frame_start && !powered_cal_done_reg;
        end
        else if (state_reg == ST_TAIL && sclk_fall &&
            edge_cnt_next == `EDGE_COUNT_WIDTH'(`RECAL_START_EDGE))
        begin
            cal_frame_reg <= 1'b1;
        end
        else if (sclk_fall && (edge_cnt_next ==
            `EDGE_COUNT_WIDTH'(`RECAL_END_EDGE) ||
            (state_reg == ST_CAL && edge_cnt_next ==
            `EDGE_COUNT_WIDTH'(`POWERUP_CAL_EDGES))))
        begin
            cal_frame_reg <= 1'b0;
        end
    end

    // Offset store: internal only, updated only when a run completes
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            offset_store_reg <= '0;
        end
        else if (sclk_fall && ((state_reg == ST_CAL && edge_cnt_next ==
            `EDGE_COUNT_WIDTH'(`POWERUP_CAL_EDGES)) ||
            (state_reg == ST_TAIL && edge_cnt_next ==
            `EDGE_COUNT_WIDTH'(`RECAL_END_EDGE))))
        begin
            offset_store_reg <= offset_measured;
        end
    end

    // ------------------------------------------------------------
    // Conversion and serial output
    // ------------------------------------------------------------
    offset_corrector #(
        .WIDTH(12)
    ) u_corr (
        .raw_code(raw_code),
        .offset(offset_store_reg),
        .corrected_code(corrected)
    );

    // Sample strobe marks the hold instant for the core
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sample_hold <= 1'b0;
        end
        else
        begin
            sample_hold <= frame_start;
        end
    end

    // Corrected result is captured on the first falling edge, so the
    // core must settle its decisions by then; zeros fill the tail
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            shift_reg <= '0;
        end
        else if (state_reg == ST_CONV && sclk_fall)
        begin
            if (edge_cnt_reg == '0)
            begin
                shift_reg <= {1'b0, corrected, 1'b0};
            end
            else
            begin
                shift_reg <= {shift_reg[12:0], 1'b0};
            end
        end
    end

    // Data line: low in calibration and tail, released outside frames
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            data_out <= 1'b0;
            data_out_en <= 1'b0;
        end
        else if (frame_end)
        begin
            data_out <= 1'b0;
            data_out_en <= 1'b0;
        end
        else if (frame_start)
        begin
            data_out <= 1'b0;
            data_out_en <= 1'b1;
        end
        else if (state_reg == ST_CONV && sclk_fall &&
            edge_cnt_next < `EDGE_COUNT_WIDTH'(`DATA_EDGES))
        begin
            data_out <= (edge_cnt_reg == '0) ? 1'b0 :
                shift_reg[12];
        end
        else if (state_reg == ST_CAL || state_reg == ST_TAIL ||
            (sclk_fall && edge_cnt_next >=
            `EDGE_COUNT_WIDTH'(`DATA_EDGES)))
        begin
            data_out <= 1'b0;
        end
    end

    assign cal_active = cal_frame_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_release_on_end: assert property (
        @(posedge clk) disable iff (!rst_b)
        frame_end |=> !data_out_en)
        else $error("data line not released at frame end");

    chk_drive_on_start: assert property (
        @(posedge clk) disable iff (!rst_b)
        frame_start |=> data_out_en && !data_out)
        else $error("first zero not driven at frame start");

    chk_cal_low: assert property (
        @(posedge clk) disable iff (!rst_b)
        state_reg == ST_CAL && !frame_end |=> !data_out)
        else $error("data high during power-up calibration");

    chk_tail_low: assert property (
        @(posedge clk) disable iff (!rst_b)
        state_reg == ST_TAIL && $past(state_reg) == ST_TAIL |-> !data_out)
        else $error("data high after fourteen clocks");

    chk_store_reset: assert property (
        @(posedge clk) disable iff (!rst_b)
        !powered_cal_done_reg |-> offset_store_reg == '0)
        else $error("offset store changed before calibration");

    chk_store_hold: assert property (
        @(posedge clk) disable iff (!rst_b)
        state_reg == ST_IDLE |=> $stable(offset_store_reg))
        else $error("offset store changed outside a frame");

    chk_tail_entry: assert property (
        @(posedge clk) disable iff (!rst_b)
        state_reg == ST_CONV && sclk_fall && !frame_end &&
        edge_cnt_reg == `EDGE_COUNT_WIDTH'(13) |=> state_reg == ST_TAIL)
        else $error("conversion did not end on fourteenth clock");

    chk_sample_strobe: assert property (
        @(posedge clk) disable iff (!rst_b)
        frame_start |=> sample_hold ##1 !sample_hold)
        else $error("sample strobe not one cycle at frame start");

endmodule // sar_readout

// file: testbench/host_master.sv
// Host side model: serial master that frames conversions, captures bits
`timescale 1ns/10ps
module host_master (
    // Serial pins
    output logic select_b,
    output logic serial_clk,
    // Resolved data pin and its enable
    input wire logic data_pin,
    input wire logic data_out_en
);
    // Idle: deselected, clock parked high and still between frames
    initial
    begin
        select_b = 1'b1;
        serial_clk = 1'b1;
    end

    // Frame of n falls; bit k is taken just before fall k+1, the last
    // one just before select rises, well clear of the 3-cycle latency
    task automatic frame(input int n, output logic [63:0] bits,
        output logic en_in, output logic en_off);
        bits = '0;
        en_in = 1'b1;
        select_b = 1'b0;
        #200;
        for (int k = 0; k <= n; k++)
        begin
            bits[k] = data_pin;
            en_in = en_in & data_out_en;
            if (k == n)
                break;
            serial_clk = 1'b0;
            #100;
            serial_clk = 1'b1;
            #100;
        end
        select_b = 1'b1;
        #200;
        en_off = data_out_en;
        // Select stays high long enough for the next acquisition
        #300;
    endtask
endmodule // host_master

// file: testbench/sar_adc_serial_readout_offset_cal_bench.sv
// Self-checking bench for the serial readout and calibration block
`timescale 1ns/10ps
module sar_adc_serial_readout_offset_cal_bench;
    import conv_pkg::*;
    logic clk, rst_b, select_b, serial_clk, data_out, data_out_en;
    logic sample_hold, cal_active, cal_seen;
    wire data_pin;
    code_t raw_code, offset_measured;
    int failures = 0;
    int samples_checked = 0;
    int store, hold_pulses, n;
    int ns [5] = '{14, 20, 31, 32, 40};
    code_t codes [3] = '{12'h000, 12'h800, 12'hfff};
    bit cal_done;

    // ----------------------------------------------------------------
    // Clock, pin resolution, instances
    // ----------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Released pin floats; the model then sees z, never an old bit
    assign data_pin = data_out_en ? data_out : 1'bz;

    sar_readout DUT (.clk(clk), .rst_b(rst_b), .select_b(select_b),
        .serial_clk(serial_clk), .data_out(data_out),
        .data_out_en(data_out_en), .raw_code(raw_code),
        .offset_measured(offset_measured), .sample_hold(sample_hold),
        .cal_active(cal_active));

    host_master host (.select_b(select_b), .serial_clk(serial_clk),
        .data_pin(data_pin), .data_out_en(data_out_en));

    // Core strobes counted per frame
    always @(posedge clk)
    begin
        if (sample_hold === 1'b1)
            hold_pulses++;
        if (cal_active === 1'b1)
            cal_seen = 1'b1;
    end

    // ----------------------------------------------------------------
    // Checking and frame tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [63:0] seen,
        input logic [63:0] want);
        samples_checked++;
        if (seen !== want)
        begin
            failures++;
            $display("wrong value %s: expected %h, seen %h", what, want,
                seen);
        end
    endtask

    // Reference model: store and calibration state kept as integers
    task automatic run(input int nf, input code_t raw, input code_t off);
        logic [63:0] got, want;
        logic en_in, en_off;
        int corr;
        bit cal_frame;
        @(negedge clk);
        raw_code = raw;
        offset_measured = off;
        hold_pulses = 0;
        cal_seen = 1'b0;
        want = '0;
        cal_frame = !cal_done;
        corr = int'(raw) - store;
        if (corr < 0)
            corr = 0;
        if (corr > 4095)
            corr = 4095;
        if (!cal_frame)
            for (int k = 2; k < 14; k++)
                want[k] = corr[13-k];
        host.frame(nf, got, en_in, en_off);
        check("frame bits", got, want);
        check("enable in frame", en_in, 1'b1);
        check("enable after frame", en_off, 1'b0);
        check("sample strobes", hold_pulses, 1);
        check("cal window", cal_seen, cal_frame || nf >= 17);
        if (cal_frame ? nf >= 16 : nf >= 32)
            store = $signed(off);
        if (nf >= 16)
            cal_done = 1'b1;
    endtask

    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask

    task automatic test_done;
        $display("checks %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Watchdog: the whole sequence needs well under half this span
    initial
    begin
        #1000000;
        failures++;
        test_done;
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        rst_b = 1'b0;
        raw_code = '0;
        offset_measured = '0;
        cal_done = 1'b0;
        store = 0;
        void'($urandom(7));
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst_b = 1'b1;
        // Short power-up frame, then the real calibration frame
        run(14, 12'h123, 12'h005);
        run(16, 12'h123, 12'h000);
        end_test("power-up calibration");
        foreach (codes[i])
            run(14, codes[i], 12'h03a);
        run(32, 12'h800, 12'h010);
        run(31, 12'h800, 12'h7ff);
        run(14, 12'h005, 12'h000);
        run(40, 12'hff8, 12'hff0);
        run(14, 12'hff8, 12'h000);
        end_test("codes and recalibration");
        repeat (6)
        begin
            n = ns[$urandom % 5];
            run(n, code_t'($urandom), code_t'(($urandom % 128) - 64));
        end
        end_test("random frames");
        // Second power-up in mid-run clears the store
        @(negedge clk);
        rst_b = 1'b0;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        cal_done = 1'b0;
        store = 0;
        run(14, 12'h400, 12'h011);
        run(20, 12'h400, 12'h011);
        run(14, 12'h400, 12'h000);
        end_test("second power-up");
        test_done;
    end
endmodule // sar_adc_serial_readout_offset_cal_bench
